// ==== hw/hlsf_status_top.sv ====
// hlsf_status_top: hdlc1 link event status register with enable mask
// assumes event inputs are one-cycle pulses on mclk from the controllers,
// and a classic wishbone master on the same clock
// ----------------------------------------------------------------
// Overview of operation
// [RULE1] bit 7 read-only last received message kind
// [RULE2] bits 6..0 sticky, cleared on read or write
// [RULE3] bit 6 set when transmit starts
// [RULE4] host loads next buffer on transmit start
// [RULE5] bit 5 set when receive starts
// [RULE6] bit 4 set when transmit ends
// [RULE7] host must load buffer before transmit end
// [RULE8] bit 3 set on receive end or full
// [RULE9] bit 2 set on frame check error
// [RULE10] bit 1 set on seven ones abort
// [RULE11] bit 0 set on flag octet seen
// [RULE12] host treats idle plus end as complete
// [RULE13] enabled flags only drive interrupt output
// [RULE14] event during clearing read stays set
// ----------------------------------------------------------------
`timescale 1ns/1ps
module hlsf_status_top (
   mclk,
   reset_n,
   wb_cyc_i,
   wb_stb_i,
   wb_we_i,
   wb_sel_i,
   wb_adr_i,
   wb_dat_i,
   wb_dat_o,
   wb_ack_o,
   events,
   rx_kind_valid,
   rx_message_kind,
   irq
);
   input wire logic mclk;
   input wire logic reset_n;
   input wire logic wb_cyc_i;
   input wire logic wb_stb_i;
   input wire logic wb_we_i;
   input wire logic [3:0] wb_sel_i;
   input wire logic [hlsf_pkg::HLSF_ADDR_W-1:0] wb_adr_i;
   input wire logic [hlsf_pkg::HLSF_DATA_W-1:0] wb_dat_i;
   output logic [hlsf_pkg::HLSF_DATA_W-1:0] wb_dat_o;
   output logic wb_ack_o;
   input wire hlsf_pkg::hlsf_event_type events;
   input wire logic rx_kind_valid;
   input wire logic rx_message_kind;
   output logic irq;

   import hlsf_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   hlsf_wb_req_type req;
   logic accept;
   logic [HLSF_EVENT_N-1:0] event_vec;
   logic [HLSF_EVENT_N-1:0] flag_vec;
   logic [HLSF_EVENT_N-1:0] clear_vec;
   logic rx_message_kind_reg;
   logic [7:0] enable_reg;
   logic [7:0] status_value;
   logic [HLSF_DATA_W-1:0] read_next;
   logic irq_next;
   logic status_read;
   logic status_write;

   // bundle the bus request
   always_comb begin
      req.cyc = wb_cyc_i;
      req.stb = wb_stb_i;
      req.we = wb_we_i;
      req.sel = wb_sel_i;
      req.adr = wb_adr_i;
      req.dat = wb_dat_i;
   end

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   hlsf_wb_slave u_bus (
      .mclk(mclk),
      .reset_n(reset_n),
      .req(req),
      .accept(accept),
      .wb_ack(wb_ack_o)
   );

   // access decode, lane 0 carries the byte-wide registers
   assign status_read = accept && !req.we && (req.adr == HLSF_STATUS_ADDR);
   assign status_write = accept && req.we && req.sel[0] && (req.adr == HLSF_STATUS_ADDR);

   // ----------------------------------------------------------------
   // event flags
   // ----------------------------------------------------------------
   // bit order of the struct matches bits 6..0 of the status register
   assign event_vec = {events.tx_start,          // RULE3
                       events.rx_start,          // RULE5
                       events.tx_end,            // RULE6
                       events.rx_end,            // RULE8
                       events.frame_check_error, // RULE9
                       events.abort,             // RULE10
                       events.idle};             // RULE11

   genvar gi;
   generate
      for (gi = 0; gi < HLSF_EVENT_N; gi++) begin : g_flag
         // read clears all, write-one clears the chosen bit
         assign clear_vec[gi] = status_read || (status_write && req.dat[gi]); // RULE2
         hlsf_event_latch u_latch (
            .mclk(mclk),
            .reset_n(reset_n),
            .event_pulse(event_vec[gi]),
            .clear(clear_vec[gi]),
            .flag(flag_vec[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // message kind
   // ----------------------------------------------------------------
   // software cannot write it; follows the receiver only
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_message_kind_reg <= HLSF_KIND_RESET;
      end else if (rx_kind_valid) begin
         rx_message_kind_reg <= rx_message_kind; // RULE1
      end
   end

   assign status_value = {rx_message_kind_reg, flag_vec};

   // ----------------------------------------------------------------
   // enable register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         enable_reg <= HLSF_ENABLE_RESET;
      end else if (accept && req.we && req.sel[0] && req.adr == HLSF_ENABLE_ADDR) begin
         enable_reg <= {1'b0, req.dat[HLSF_EVENT_N-1:0]};
      end
   end

   // ----------------------------------------------------------------
   // read data, captured at accept and held with ack
   // ----------------------------------------------------------------
   always_comb begin
      read_next = '0;
      if (req.adr == HLSF_STATUS_ADDR) begin
         read_next[7:0] = status_value;
      end else if (req.adr == HLSF_ENABLE_ADDR) begin
         read_next[7:0] = enable_reg;
      end else if (req.adr == HLSF_PENDING_ADDR) begin
         read_next[7:0] = {1'b0, flag_vec & enable_reg[HLSF_EVENT_N-1:0]};
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= '0;
      end else if (accept && !req.we) begin
         wb_dat_o <= read_next;
      end
   end

   // ----------------------------------------------------------------
   // interrupt output
   // ----------------------------------------------------------------
   assign irq_next = |(flag_vec & enable_reg[HLSF_EVENT_N-1:0]); // RULE13

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_next;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_rd_accept;
      status_read;
   endsequence

   sequence s_any_clear;
      (|clear_vec);
   endsequence

   property p_kind_follows;
      @(posedge mclk) disable iff (!reset_n)
      rx_kind_valid |=> rx_message_kind_reg == $past(rx_message_kind);
   endproperty
   a_kind_follows: assert property (p_kind_follows) // RULE1
      else $error("message kind not captured");

   property p_kind_not_written;
      @(posedge mclk) disable iff (!reset_n)
      !rx_kind_valid |=> $stable(rx_message_kind_reg);
   endproperty
   a_kind_not_written: assert property (p_kind_not_written) // RULE1
      else $error("message kind changed without receiver");

   property p_read_clears;
      @(posedge mclk) disable iff (!reset_n)
      s_rd_accept ##0 (event_vec == '0) |=> flag_vec == '0;
   endproperty
   a_read_clears: assert property (p_read_clears) // RULE2
      else $error("read did not clear flags");

   property p_tx_start_sets;
      @(posedge mclk) disable iff (!reset_n)
      events.tx_start |=> flag_vec[HLSF_TX_START_BIT];
   endproperty
   a_tx_start_sets: assert property (p_tx_start_sets) // RULE3
      else $error("transmit start flag not set");

   property p_rx_start_sets;
      @(posedge mclk) disable iff (!reset_n)
      events.rx_start |=> flag_vec[HLSF_RX_START_BIT];
   endproperty
   a_rx_start_sets: assert property (p_rx_start_sets) // RULE5
      else $error("receive start flag not set");

   property p_tx_end_sets;
      @(posedge mclk) disable iff (!reset_n)
      events.tx_end |=> flag_vec[HLSF_TX_END_BIT];
   endproperty
   a_tx_end_sets: assert property (p_tx_end_sets) // RULE6
      else $error("transmit end flag not set");

   property p_rx_end_sets;
      @(posedge mclk) disable iff (!reset_n)
      events.rx_end |=> flag_vec[HLSF_RX_END_BIT];
   endproperty
   a_rx_end_sets: assert property (p_rx_end_sets) // RULE8
      else $error("receive end flag not set");

   property p_fcs_sets;
      @(posedge mclk) disable iff (!reset_n)
      events.frame_check_error |=> flag_vec[HLSF_FCS_BIT];
   endproperty
   a_fcs_sets: assert property (p_fcs_sets) // RULE9
      else $error("frame check flag not set");

   property p_abort_sets;
      @(posedge mclk) disable iff (!reset_n)
      events.abort |=> flag_vec[HLSF_ABORT_BIT];
   endproperty
   a_abort_sets: assert property (p_abort_sets) // RULE10
      else $error("abort flag not set");

   property p_idle_sets;
      @(posedge mclk) disable iff (!reset_n)
      events.idle |=> flag_vec[HLSF_IDLE_BIT];
   endproperty
   a_idle_sets: assert property (p_idle_sets) // RULE11
      else $error("idle flag not set");

   property p_irq_masked;
      @(posedge mclk) disable iff (!reset_n)
      ##1 irq == $past(irq_next);
   endproperty
   a_irq_masked: assert property (p_irq_masked) // RULE13
      else $error("interrupt does not follow enabled flags");

   property p_collision_kept;
      @(posedge mclk) disable iff (!reset_n)
      s_rd_accept |=> (flag_vec & $past(event_vec)) == $past(event_vec);
   endproperty
   a_collision_kept: assert property (p_collision_kept) // RULE14
      else $error("event lost during clearing read");

   property p_clear_applied;
      @(posedge mclk) disable iff (!reset_n)
      s_any_clear |=> (flag_vec & $past(clear_vec) & ~$past(event_vec)) == '0;
   endproperty
   a_clear_applied: assert property (p_clear_applied) // RULE2
      else $error("cleared flag still set");

   property p_no_spurious_set;
      @(posedge mclk) disable iff (!reset_n)
      ##1 (flag_vec & ~$past(flag_vec) & ~$past(event_vec)) == '0;
   endproperty
   a_no_spurious_set: assert property (p_no_spurious_set) // RULE2
      else $error("flag set without its event");

   property p_status_data;
      @(posedge mclk) disable iff (!reset_n)
      s_rd_accept |=> wb_dat_o == {24'h000000, $past(status_value)};
   endproperty
   a_status_data: assert property (p_status_data) // RULE1
      else $error("status read data wrong");

   property p_dat_held;
      @(posedge mclk) disable iff (!reset_n)
      !(accept && !req.we) |=> $stable(wb_dat_o);
   endproperty
   a_dat_held: assert property (p_dat_held) // RULE2
      else $error("read data changed without a read");

   property p_ack_after_accept;
      @(posedge mclk) disable iff (!reset_n)
      accept |=> wb_ack_o;
   endproperty
   a_ack_after_accept: assert property (p_ack_after_accept) // RULE2
      else $error("taken request not acknowledged");

   property p_ack_pulse;
      @(posedge mclk) disable iff (!reset_n)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) // RULE2
      else $error("acknowledge longer than one cycle");

   property p_kind_read_only;
      @(posedge mclk) disable iff (!reset_n)
      status_write && !rx_kind_valid |=> $stable(rx_message_kind_reg);
   endproperty
   a_kind_read_only: assert property (p_kind_read_only) // RULE1
      else $error("message kind changed by a write");

   property p_irq_low;
      @(posedge mclk) disable iff (!reset_n)
      (flag_vec & enable_reg[HLSF_EVENT_N-1:0]) == '0 |=> !irq;
   endproperty
   a_irq_low: assert property (p_irq_low) // RULE13
      else $error("interrupt high with no enabled flag");

   property p_irq_high;
      @(posedge mclk) disable iff (!reset_n)
      (flag_vec & enable_reg[HLSF_EVENT_N-1:0]) != '0 |=> irq;
   endproperty
   a_irq_high: assert property (p_irq_high) // RULE13
      else $error("interrupt low with an enabled flag");

   property p_enable_top_zero;
      @(posedge mclk) disable iff (!reset_n)
      enable_reg[HLSF_KIND_BIT] == 1'b0;
   endproperty
   a_enable_top_zero: assert property (p_enable_top_zero) // RULE13
      else $error("unused enable bit set");

endmodule

// ==== hw/hlsf_pkg.sv ====
// hlsf_pkg: constants and types for the hdlc1 link event status block
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
package hlsf_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] HLSF_STATUS_ADDR = 8'h00;
   localparam logic [7:0] HLSF_ENABLE_ADDR = 8'h04;
   localparam logic [7:0] HLSF_PENDING_ADDR = 8'h08;
   localparam int HLSF_ADDR_W = 8;
   localparam int HLSF_DATA_W = 32;

   // ----------------------------------------------------------------
   // field layout of the status register
   // ----------------------------------------------------------------
   localparam int HLSF_KIND_BIT = 7;
   localparam int HLSF_TX_START_BIT = 6;
   localparam int HLSF_RX_START_BIT = 5;
   localparam int HLSF_TX_END_BIT = 4;
   localparam int HLSF_RX_END_BIT = 3;
   localparam int HLSF_FCS_BIT = 2;
   localparam int HLSF_ABORT_BIT = 1;
   localparam int HLSF_IDLE_BIT = 0;
   localparam int HLSF_EVENT_N = 7;
   localparam logic [6:0] HLSF_EVENT_RESET = 7'h00;
   localparam logic [7:0] HLSF_ENABLE_RESET = 8'h00;
   localparam logic HLSF_KIND_RESET = 1'b0;

   // message kind encoding
   localparam logic HLSF_BIT_ORIENTED_KIND = 1'b0;
   localparam logic HLSF_MESSAGE_ORIENTED_KIND = 1'b1;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic tx_start;
      logic rx_start;
      logic tx_end;
      logic rx_end;
      logic frame_check_error;
      logic abort;
      logic idle;
   } hlsf_event_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [HLSF_ADDR_W-1:0] adr;
      logic [HLSF_DATA_W-1:0] dat;
   } hlsf_wb_req_type;

   typedef enum logic [1:0] {
      HLSF_BUS_IDLE = 2'b00,
      HLSF_BUS_ACK = 2'b01,
      HLSF_BUS_WAIT = 2'b10
   } hlsf_bus_state_type;

endpackage

// ==== hw/hlsf_event_latch.sv ====
// hlsf_event_latch: one sticky event flag with set-wins clear
// assumes event pulses are synchronous to mclk
`timescale 1ns/1ps
module hlsf_event_latch (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic event_pulse,
   input wire logic clear,
   output logic flag
);
   // ----------------------------------------------------------------
   // sticky flag
   // ----------------------------------------------------------------
   // set has priority so a colliding event survives the clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flag <= 1'b0;
      end else if (event_pulse) begin
         flag <= 1'b1; // RULE2 RULE14
      end else if (clear) begin
         flag <= 1'b0; // RULE2
      end
   end
endmodule

// ==== hw/hlsf_wb_slave.sv ====
// hlsf_wb_slave: classic wishbone handshake, one ack per request
// assumes master holds the request until ack and drops cyc after it
`timescale 1ns/1ps
module hlsf_wb_slave (
   input wire logic mclk,
   input wire logic reset_n,
   input wire hlsf_pkg::hlsf_wb_req_type req,
   output logic accept,
   output logic wb_ack
);
   import hlsf_pkg::*;

   hlsf_bus_state_type state_reg;

   // ----------------------------------------------------------------
   // handshake: accept one cycle, ack next, then wait for release
   // ----------------------------------------------------------------
   assign accept = (state_reg == HLSF_BUS_IDLE) && req.cyc && req.stb;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= HLSF_BUS_IDLE;
         wb_ack <= 1'b0;
      end else begin
         unique case (state_reg)
            HLSF_BUS_IDLE: begin
               wb_ack <= accept;
               if (accept) begin
                  state_reg <= HLSF_BUS_ACK;
               end
            end
            HLSF_BUS_ACK: begin
               wb_ack <= 1'b0;
               state_reg <= HLSF_BUS_WAIT;
            end
            HLSF_BUS_WAIT: begin
               wb_ack <= 1'b0;
               if (!(req.cyc && req.stb)) begin
                  state_reg <= HLSF_BUS_IDLE;
               end
            end
            default: begin
               wb_ack <= 1'b0;
               state_reg <= HLSF_BUS_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== verif/hlsf_tb.sv ====
// testbench: self-checking bench for the hdlc1 link event status block
// assumes hlsf_pkg and hlsf_status_top are compiled first, one clock domain
`timescale 1ns/1ps
module testbench;
   import hlsf_pkg::*;

   // ----------------------------------------------------------------
   // signals and reference model state
   // ----------------------------------------------------------------
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   hlsf_event_type events = '0;
   logic rx_kind_valid = 1'b0;
   logic rx_message_kind = 1'b0;
   logic irq;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [6:0] m_flags = 7'h00;
   logic [6:0] m_enable = 7'h00;
   logic m_kind = 1'b0;

   // 50 MHz clock
   always #10 mclk = ~mclk;

   hlsf_status_top uut (
      .mclk(mclk),
      .reset_n(reset_n),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i),
      .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .events(events),
      .rx_kind_valid(rx_kind_valid),
      .rx_message_kind(rx_message_kind),
      .irq(irq)
   );

   // ----------------------------------------------------------------
   // compare tasks and closing report
   // ----------------------------------------------------------------
   task automatic check_data(input string name, input logic [31:0] exp, input logic [31:0] seen);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic check_irq(input logic exp);
      checks_done++;
      if (irq !== exp) begin
         fail_count++;
         $display("wrong value irq expected %b seen %b", exp, irq);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // model view of a register read
   function automatic logic [31:0] model_read(input logic [7:0] adr);
      case (adr)
         HLSF_STATUS_ADDR: return {24'h000000, m_kind, m_flags};
         HLSF_ENABLE_ADDR: return {25'h0000000, m_enable};
         HLSF_PENDING_ADDR: return {25'h0000000, m_flags & m_enable};
         default: return 32'h00000000;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // bus and event drivers
   // ----------------------------------------------------------------
   // one classic wishbone cycle, events optionally pulsed at the taking edge
   task automatic wb_op(input logic we, input logic [7:0] adr, input logic [31:0] dat,
         input logic [3:0] sel, input logic [6:0] ev);
      logic [31:0] exp;
      int n;
      exp = model_read(adr);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      events <= ev;
      n = 0;
      do begin
         @(posedge mclk);
         events <= '0;
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         $display("wrong value ack expected 1 seen timeout");
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (!we) begin
         check_data("read data", exp, wb_dat_o);
         if (adr == HLSF_STATUS_ADDR) m_flags = 7'h00;
      end else if (sel[0]) begin
         if (adr == HLSF_STATUS_ADDR) m_flags = m_flags & ~dat[6:0];
         if (adr == HLSF_ENABLE_ADDR) m_enable = dat[6:0];
      end
      // set wins over a clear in the same cycle
      m_flags = m_flags | ev;
      #1 check_irq(|(m_flags & m_enable));
   endtask

   // event and message kind pulse, irq checked one edge after the flag
   task automatic pulse(input logic [6:0] ev, input logic kv, input logic kind);
      @(posedge mclk);
      events <= ev;
      rx_kind_valid <= kv;
      rx_message_kind <= kind;
      @(posedge mclk);
      events <= '0;
      rx_kind_valid <= 1'b0;
      rx_message_kind <= ~kind;
      m_flags = m_flags | ev;
      if (kv) m_kind = kind;
      @(posedge mclk);
      #1 check_irq(|(m_flags & m_enable));
   endtask

   // ----------------------------------------------------------------
   // timeout and main sequence
   // ----------------------------------------------------------------
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         fail_count++;
         stop_test();
      end
   end

   initial begin
      int i;
      logic [7:0] a;
      void'($urandom(36748));
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      // reset values
      wb_op(1'b0, HLSF_STATUS_ADDR, 32'h0, 4'hF, 7'h00);
      wb_op(1'b0, HLSF_ENABLE_ADDR, 32'h0, 4'hF, 7'h00);
      // each event alone, enabled, then cleared by a read
      for (i = 0; i < 7; i++) begin
         wb_op(1'b1, HLSF_ENABLE_ADDR, 32'h1 << i, 4'h1, 7'h00);
         pulse(7'h01 << i, 1'b1, i[0]);
         wb_op(1'b0, HLSF_PENDING_ADDR, 32'h0, 4'hF, 7'h00);
         wb_op(1'b0, HLSF_STATUS_ADDR, 32'h0, 4'hF, 7'h00);
         wb_op(1'b0, HLSF_STATUS_ADDR, 32'h0, 4'hF, 7'h00);
      end
      // write-one clears, bit 7 read-only, sel lane 0 gates the write
      pulse(7'h7F, 1'b1, 1'b1);
      wb_op(1'b1, HLSF_STATUS_ADDR, 32'hD5, 4'h1, 7'h00);
      wb_op(1'b1, HLSF_STATUS_ADDR, 32'hFF, 4'hE, 7'h00);
      wb_op(1'b0, HLSF_STATUS_ADDR, 32'h0, 4'hF, 7'h00);
      // event arriving with the clearing read survives
      pulse(7'h7F, 1'b0, 1'b0);
      wb_op(1'b0, HLSF_STATUS_ADDR, 32'h0, 4'hF, 7'h24);
      wb_op(1'b0, HLSF_STATUS_ADDR, 32'h0, 4'hF, 7'h00);
      // host view: start seen before end, idle with end marks a whole message
      pulse(7'h40, 1'b0, 1'b0);
      wb_op(1'b0, HLSF_STATUS_ADDR, 32'h0, 4'hF, 7'h00);
      pulse(7'h10, 1'b0, 1'b0);
      pulse(7'h09, 1'b1, 1'b1);
      wb_op(1'b0, HLSF_STATUS_ADDR, 32'h0, 4'hF, 7'h00);
      // masked flags latch without interrupt
      wb_op(1'b1, HLSF_ENABLE_ADDR, 32'h00, 4'h1, 7'h00);
      pulse(7'h7F, 1'b1, 1'b0);
      wb_op(1'b0, HLSF_STATUS_ADDR, 32'h0, 4'hF, 7'h00);
      // unmapped address
      wb_op(1'b1, 8'h0C, 32'hFF, 4'hF, 7'h00);
      wb_op(1'b0, 8'h0C, 32'h0, 4'hF, 7'h00);
      // random traffic mixed with events
      for (i = 0; i < 60; i++) begin
         a = 8'(($urandom % 4) * 4);
         wb_op(1'($urandom), a, $urandom, 4'($urandom), 7'($urandom));
         if ($urandom % 2) pulse(7'($urandom), 1'($urandom), 1'($urandom));
      end
      stop_test();
   end
endmodule
